//--- src/peripheral_interrupt_flags.sv
// peripheral interrupt request flag bank with enables and request output
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_flags
    import pif_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire reg_req_type req,
    output logic [DATA_W-1:0] rd_data,
    // peripheral events
    input wire periph_event_type ev,
    input wire logic [2:0][POSTSCALE_W-1:0] postscale,
    input wire ccp_mode_type [3:0] ccp_mode,
    // requests to the processor
    output logic peripheral_irq,
    output logic cpu_irq
);

    logic [7:0] analog_flags;
    logic [7:0] serial_flags;
    logic [7:0] timer_flags;
    logic [7:0] lcg_flags;
    logic [7:0] ccp_flags;
    logic [7:0] analog_enable;
    logic [7:0] serial_enable;
    logic [7:0] timer_enable;
    logic [7:0] lcg_enable;
    logic [7:0] ccp_enable;
    logic [7:0] irq_control;
    logic [7:0] next_analog;
    logic [7:0] next_serial;
    logic [7:0] next_timer;
    logic [7:0] next_lcg;
    logic [7:0] next_ccp;
    logic [7:0] analog_set;
    logic [7:0] serial_set;
    logic [7:0] timer_set;
    logic [7:0] lcg_set;
    logic [7:0] ccp_set;
    logic [2:0] period_event;
    logic [2:0] gate_prev;
    logic [2:0] gate_fell;
    logic [3:0] ccp_event;
    logic any_pending;

    // ------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_post
            period_postscaler u_post (
                .mclk(mclk),
                .rst_n(rst_n),
                .period_match(ev.period_match[gi]),
                .ratio(postscale[gi]),
                .overflow(period_event[gi])
            );
        end
    endgenerate

    // gate level is kept one cycle to spot its falling edge
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_prev <= 3'h0;
        end
        else
        begin
            gate_prev <= ev.gate_level;
        end
    end

    assign gate_fell = gate_prev & ~ev.gate_level;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            case (ccp_mode[i])
                CCP_CAPTURE: ccp_event[i] = ev.capture[i];
                CCP_COMPARE: ccp_event[i] = ev.compare[i];
                CCP_PWM: ccp_event[i] = ev.pwm_trailing[i];
                default: ccp_event[i] = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // set vectors, laid out as the register fields
    // ------------------------------------------------------------
    always_comb
    begin
        analog_set = 8'h00;
        analog_set[ZERO_CROSS_BIT] = ev.zero_cross;
        analog_set[COMPARATOR_LSB +: 2] = ev.comparator;
        serial_set = 8'h00;
        serial_set[BUS_COLLISION_BIT] = ev.bus_collision;
        serial_set[SYNC_PORT_DONE_BIT] = ev.sync_done;
        timer_set = {2'b00, period_event[2], ev.overflow[2], period_event[1],
            ev.overflow[1], period_event[0], ev.overflow[0]};
        lcg_set = {ev.logic_cell, 1'b0, gate_fell};
        ccp_set = {4'h0, ccp_event};
    end

    // ------------------------------------------------------------
    // next flag values: a hardware set always beats a software clear
    // ------------------------------------------------------------
    function automatic logic [7:0] flag_next(
        input logic [7:0] cur,
        input logic [7:0] set,
        input logic [7:0] mask,
        input logic [7:0] data,
        input logic hit
    );
        logic [7:0] base;
        base = hit ? (data & mask) : cur;
        return (base | set) & mask;
    endfunction

    // write data goes in as an argument so every change of it re-evaluates
    assign next_analog = flag_next(analog_flags, analog_set, ANALOG_MASK, req.wdata,
        req.write && req.addr == ANALOG_FLAGS_OFFSET);
    assign next_timer = flag_next(timer_flags, timer_set, TIMER_MASK, req.wdata,
        req.write && req.addr == TIMER_FLAGS_OFFSET);
    assign next_lcg = flag_next(lcg_flags, lcg_set, LCG_MASK, req.wdata,
        req.write && req.addr == LCG_FLAGS_OFFSET);
    assign next_ccp = flag_next(ccp_flags, ccp_set, CCP_MASK, req.wdata,
        req.write && req.addr == CCP_FLAGS_OFFSET);

    // buffer status bits follow their levels; writes never reach them
    always_comb
    begin
        next_serial = flag_next(serial_flags, serial_set, SERIAL_WRITE_MASK, req.wdata,
            req.write && req.addr == SERIAL_FLAGS_OFFSET);
        next_serial[RECEIVE_PENDING_BIT] = ev.rx_not_empty;
        next_serial[TRANSMIT_SPACE_BIT] = ev.tx_has_space;
    end

    // ------------------------------------------------------------
    // flag registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            analog_flags <= REG_RESET;
            serial_flags <= REG_RESET;
            timer_flags <= REG_RESET;
            lcg_flags <= REG_RESET;
            ccp_flags <= REG_RESET;
        end
        else
        begin
            analog_flags <= next_analog;
            serial_flags <= next_serial;
            timer_flags <= next_timer;
            lcg_flags <= next_lcg;
            ccp_flags <= next_ccp;
        end
    end

    // ------------------------------------------------------------
    // enable and control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            analog_enable <= REG_RESET;
            serial_enable <= REG_RESET;
            timer_enable <= REG_RESET;
            lcg_enable <= REG_RESET;
            ccp_enable <= REG_RESET;
            irq_control <= REG_RESET;
        end
        else if (req.write)
        begin
            case (req.addr)
                ANALOG_ENABLE_OFFSET: analog_enable <= req.wdata & ANALOG_MASK;
                SERIAL_ENABLE_OFFSET: serial_enable <= req.wdata & SERIAL_MASK;
                TIMER_ENABLE_OFFSET: timer_enable <= req.wdata & TIMER_MASK;
                LCG_ENABLE_OFFSET: lcg_enable <= req.wdata & LCG_MASK;
                CCP_ENABLE_OFFSET: ccp_enable <= req.wdata & CCP_MASK;
                IRQ_CONTROL_OFFSET: irq_control <= req.wdata & IRQ_CONTROL_MASK;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= REG_RESET;
        end
        else if (req.read)
        begin
            case (req.addr)
                ANALOG_FLAGS_OFFSET: rd_data <= analog_flags;
                SERIAL_FLAGS_OFFSET: rd_data <= serial_flags;
                TIMER_FLAGS_OFFSET: rd_data <= timer_flags;
                LCG_FLAGS_OFFSET: rd_data <= lcg_flags;
                CCP_FLAGS_OFFSET: rd_data <= ccp_flags;
                ANALOG_ENABLE_OFFSET: rd_data <= analog_enable;
                SERIAL_ENABLE_OFFSET: rd_data <= serial_enable;
                TIMER_ENABLE_OFFSET: rd_data <= timer_enable;
                LCG_ENABLE_OFFSET: rd_data <= lcg_enable;
                CCP_ENABLE_OFFSET: rd_data <= ccp_enable;
                IRQ_CONTROL_OFFSET: rd_data <= irq_control;
                default: rd_data <= 8'h00;
            endcase
        end
        else
        begin
            rd_data <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // request to the processor
    // ------------------------------------------------------------
    // stale flags fire at once when enabled, so software clears first
    assign any_pending = |(analog_flags & analog_enable) | |(serial_flags & serial_enable)
        | |(timer_flags & timer_enable) | |(lcg_flags & lcg_enable)
        | |(ccp_flags & ccp_enable);
    assign peripheral_irq = any_pending && irq_control[PERIPHERAL_IRQ_ENABLE_BIT];
    assign cpu_irq = peripheral_irq && irq_control[GLOBAL_IRQ_ENABLE_BIT];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_clear_analog;
        req.write && req.addr == ANALOG_FLAGS_OFFSET && req.wdata == 8'h00;
    endsequence

    sequence s_read_serial;
        req.read && req.addr == SERIAL_FLAGS_OFFSET;
    endsequence

    property p_zero_cross_set;
        ev.zero_cross |=> analog_flags[ZERO_CROSS_BIT];
    endproperty
    a_zero_cross_set: assert property (p_zero_cross_set)
        else $error("zero-cross flag not set");

    property p_comparator_held;
        analog_flags[1] && !req.write [*2] |=> analog_flags[1];
    endproperty
    a_comparator_held: assert property (p_comparator_held)
        else $error("comparator flag lost");

    property p_set_beats_clear;
        s_clear_analog and ev.comparator[0] |=> analog_flags[0];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("event lost against clear");

    property p_receive_level;
        s_read_serial |=> rd_data[RECEIVE_PENDING_BIT] == $past(ev.rx_not_empty, 2);
    endproperty
    a_receive_level: assert property (p_receive_level)
        else $error("receive flag does not follow buffer");

    // the edge that releases reset still runs the reset branch, so skip it
    property p_transmit_level;
        $past(rst_n) |-> serial_flags[TRANSMIT_SPACE_BIT] == $past(ev.tx_has_space);
    endproperty
    a_transmit_level: assert property (p_transmit_level)
        else $error("transmit flag does not follow space");

    property p_collision_set;
        ev.bus_collision |=> serial_flags[BUS_COLLISION_BIT] [*1] ##0 !serial_flags[7];
    endproperty
    a_collision_set: assert property (p_collision_set)
        else $error("collision flag not set");

    property p_sync_done_set;
        ev.sync_done |=> serial_flags[SYNC_PORT_DONE_BIT];
    endproperty
    a_sync_done_set: assert property (p_sync_done_set)
        else $error("sync port flag not set");

    property p_overflow_set;
        ev.overflow[2] |=> timer_flags[4];
    endproperty
    a_overflow_set: assert property (p_overflow_set)
        else $error("overflow timer flag not set");

    property p_one_to_one;
        ev.period_match[1] && postscale[1] == POSTSCALE_ONE_TO_ONE |=> timer_flags[3];
    endproperty
    a_one_to_one: assert property (p_one_to_one)
        else $error("period flag missed at 1:1");

    property p_gate_done;
        $fell(ev.gate_level[2]) |=> lcg_flags[2];
    endproperty
    a_gate_done: assert property (p_gate_done)
        else $error("gate done flag not set");

    property p_pwm_edge;
        ccp_mode[3] == CCP_PWM && ev.pwm_trailing[3] |=> ccp_flags[3];
    endproperty
    a_pwm_edge: assert property (p_pwm_edge)
        else $error("pwm trailing edge flag not set");

    property p_enable_gating;
        !irq_control[PERIPHERAL_IRQ_ENABLE_BIT] |-> !peripheral_irq && !cpu_irq;
    endproperty
    a_enable_gating: assert property (p_enable_gating)
        else $error("request without peripheral enable");

    property p_reserved_zero;
        s_read_serial |=> rd_data[7:6] == 2'b00 && rd_data[3:2] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

endmodule // peripheral_interrupt_flags
`default_nettype wire

//--- src/pif_pkg.sv
// package: offsets, field layout and carriers of the peripheral flag bank
package pif_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] IRQ_CONTROL_OFFSET = 12'h70B;
    localparam logic [11:0] ANALOG_FLAGS_OFFSET = 12'h70E;
    localparam logic [11:0] SERIAL_FLAGS_OFFSET = 12'h70F;
    localparam logic [11:0] TIMER_FLAGS_OFFSET = 12'h710;
    localparam logic [11:0] LCG_FLAGS_OFFSET = 12'h711;
    localparam logic [11:0] CCP_FLAGS_OFFSET = 12'h712;
    localparam logic [11:0] ANALOG_ENABLE_OFFSET = 12'h718;
    localparam logic [11:0] SERIAL_ENABLE_OFFSET = 12'h719;
    localparam logic [11:0] TIMER_ENABLE_OFFSET = 12'h71A;
    localparam logic [11:0] LCG_ENABLE_OFFSET = 12'h71B;
    localparam logic [11:0] CCP_ENABLE_OFFSET = 12'h71C;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // implemented bits of each register
    // ------------------------------------------------------------
    localparam logic [7:0] ANALOG_MASK = 8'h43;
    localparam logic [7:0] SERIAL_MASK = 8'h33;
    localparam logic [7:0] SERIAL_WRITE_MASK = 8'h03;
    localparam logic [7:0] TIMER_MASK = 8'h3F;
    localparam logic [7:0] LCG_MASK = 8'hF7;
    localparam logic [7:0] CCP_MASK = 8'h0F;
    localparam logic [7:0] IRQ_CONTROL_MASK = 8'hC0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ZERO_CROSS_BIT = 6;
    localparam int COMPARATOR_LSB = 0;
    localparam int RECEIVE_PENDING_BIT = 5;
    localparam int TRANSMIT_SPACE_BIT = 4;
    localparam int BUS_COLLISION_BIT = 1;
    localparam int SYNC_PORT_DONE_BIT = 0;
    localparam int LOGIC_CELL_LSB = 4;
    localparam int GATE_DONE_LSB = 0;
    localparam int CAPCOMP_LSB = 0;
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int POSTSCALE_W = 4;
    localparam logic [3:0] POSTSCALE_ONE_TO_ONE = 4'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CCP_CAPTURE, CCP_COMPARE, CCP_PWM, CCP_OFF} ccp_mode_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [11:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic zero_cross;
        logic [1:0] comparator;
        logic rx_not_empty;
        logic tx_has_space;
        logic bus_collision;
        logic sync_done;
        logic [2:0] overflow;
        logic [2:0] period_match;
        logic [3:0] logic_cell;
        logic [2:0] gate_level;
        logic [3:0] capture;
        logic [3:0] compare;
        logic [3:0] pwm_trailing;
    } periph_event_type;

endpackage

//--- src/period_postscaler.sv
// postscaler that turns timer period matches into flag events
`timescale 1ns/1ps
`default_nettype none
module period_postscaler
    import pif_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // match in, ratio select
    input wire logic period_match,
    input wire logic [POSTSCALE_W-1:0] ratio,
    // event out
    output logic overflow
);

    logic [POSTSCALE_W-1:0] count;

    // ratio 0 is 1:1, so every match passes straight through
    assign overflow = period_match && (count >= ratio);

    // ------------------------------------------------------------
    // match counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
        end
        else if (overflow)
        begin
            count <= '0;
        end
        else if (period_match)
        begin
            count <= count + 4'h1;
        end
    end

endmodule // period_postscaler
`default_nettype wire

//--- verification/periph_model.sv
// behavioural model of the peripherals that raise flag events
`timescale 1ns/1ps
`default_nettype none
module periph_model
    import pif_pkg::*;
#(
    parameter int RX_DEPTH = 2,
    parameter int TX_DEPTH = 2
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // stimulus from the bench
    input wire periph_event_type pulse,
    input wire logic [2:0] gate,
    input wire logic [3:0] ops,
    // events into the flag bank
    output var periph_event_type ev
);
    int rx_count;
    int tx_count;

    // ------------------------------------------------------------
    // serial buffers: ops is rx push, rx pop, tx push, tx pop
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_count <= 0;
            tx_count <= 0;
        end
        else
        begin
            // only reads by software drain the receive side
            rx_count <= rx_count + int'(ops[3] && rx_count < RX_DEPTH)
                - int'(ops[2] && rx_count > 0);
            // a push into a full buffer is dropped, as real hardware would
            tx_count <= tx_count + int'(ops[1] && tx_count < TX_DEPTH)
                - int'(ops[0] && tx_count > 0);
        end
    end

    // ------------------------------------------------------------
    // event outputs
    // ------------------------------------------------------------
    always_comb
    begin
        ev = pulse;
        ev.rx_not_empty = (rx_count != 0);
        // a pop means the shifter took a byte, not that it went out
        ev.tx_has_space = (tx_count < TX_DEPTH);
        ev.gate_level = gate;
    end
endmodule // periph_model
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the peripheral flag bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pif_pkg::*;
    logic mclk;
    logic rst_n;
    reg_req_type req;
    logic [7:0] rd_data;
    periph_event_type pulse;
    periph_event_type ev;
    logic [2:0] gate;
    logic [3:0] ops;
    logic [2:0][POSTSCALE_W-1:0] postscale;
    ccp_mode_type [3:0] ccp_mode;
    logic peripheral_irq;
    logic cpu_irq;
    int bad_count;
    int check_count;
    int cycles;

    peripheral_interrupt_flags u_peripheral_interrupt_flags (.mclk(mclk), .rst_n(rst_n),
        .req(req), .rd_data(rd_data), .ev(ev), .postscale(postscale), .ccp_mode(ccp_mode),
        .peripheral_irq(peripheral_irq), .cpu_irq(cpu_irq));
    periph_model u_periph_model (.mclk(mclk), .rst_n(rst_n), .pulse(pulse), .gate(gate),
        .ops(ops), .ev(ev));

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    // the whole run needs a few hundred cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{write: 1'h1, read: 1'h0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        req <= '{write: 1'h0, read: 1'h1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        req <= '0;
        #1;
        chk(what, exp, rd_data);
    endtask
    task automatic fire(input periph_event_type p);
        @(posedge mclk);
        pulse <= p;
        @(posedge mclk);
        pulse <= '0;
    endtask
    task automatic buf_op(input logic [3:0] o);
        @(posedge mclk);
        ops <= o;
        @(posedge mclk);
        ops <= 4'h0;
    endtask
    // event with all enables off, read, then software clear
    task automatic flag_case(input periph_event_type p, input logic [11:0] a,
                             input logic [7:0] exp, input logic [7:0] idle);
        fire(p);
        rd(a, exp, "flag set");
        wr(a, 8'h00);
        rd(a, idle, "flag cleared");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(ANALOG_FLAGS_OFFSET, 8'h00, "analog reset");
        rd(SERIAL_FLAGS_OFFSET, 8'h10, "serial reset");
        rd(TIMER_FLAGS_OFFSET, 8'h00, "timer reset");
        rd(LCG_FLAGS_OFFSET, 8'h00, "cell reset");
        rd(CCP_FLAGS_OFFSET, 8'h00, "ccp reset");
        wr(12'h7FF, 8'hFF);
        rd(12'h7FF, 8'h00, "unmapped");
        @(posedge mclk);
        #1;
        chk("read idle", 8'h00, rd_data);
    endtask
    task automatic t_pulses();
        periph_event_type p;
        p = '0;
        p.zero_cross = 1'h1;
        flag_case(p, ANALOG_FLAGS_OFFSET, 8'h40, 8'h00);
        p = '0;
        p.comparator = 2'h2;
        flag_case(p, ANALOG_FLAGS_OFFSET, 8'h02, 8'h00);
        p = '0;
        p.bus_collision = 1'h1;
        flag_case(p, SERIAL_FLAGS_OFFSET, 8'h12, 8'h10);
        p = '0;
        p.sync_done = 1'h1;
        flag_case(p, SERIAL_FLAGS_OFFSET, 8'h11, 8'h10);
        p = '0;
        p.overflow = 3'h6;
        flag_case(p, TIMER_FLAGS_OFFSET, 8'h14, 8'h00);
        p = '0;
        p.logic_cell = 4'h3;
        flag_case(p, LCG_FLAGS_OFFSET, 8'h30, 8'h00);
    endtask
    task automatic t_ccp();
        periph_event_type p;
        for (int m = 0; m < 4; m++)
        begin
            @(posedge mclk);
            for (int c = 0; c < 4; c++)
                ccp_mode[c] <= ccp_mode_type'(m);
            p = '0;
            p.capture = 4'h1;
            p.compare = 4'h2;
            p.pwm_trailing = 4'hC;
            flag_case(p, CCP_FLAGS_OFFSET,
                (m == 3) ? 8'h00 : (m == 2) ? 8'h0C : 8'h01 << m, 8'h00);
        end
    endtask
    task automatic t_reserved();
        logic [11:0] a[5];
        logic [7:0] e[5];
        logic [11:0] en[6];
        logic [7:0] em[6];
        a = '{ANALOG_FLAGS_OFFSET, SERIAL_FLAGS_OFFSET, TIMER_FLAGS_OFFSET, LCG_FLAGS_OFFSET,
              CCP_FLAGS_OFFSET};
        e = '{8'h43, 8'h13, 8'h3F, 8'hF7, 8'h0F};
        en = '{ANALOG_ENABLE_OFFSET, SERIAL_ENABLE_OFFSET, TIMER_ENABLE_OFFSET,
               LCG_ENABLE_OFFSET, CCP_ENABLE_OFFSET, IRQ_CONTROL_OFFSET};
        em = '{8'h43, 8'h33, 8'h3F, 8'hF7, 8'h0F, 8'hC0};
        // one enable at a time, so no request can reach the outputs
        for (int i = 0; i < 6; i++)
        begin
            wr(en[i], 8'hFF);
            rd(en[i], em[i], "enable all ones");
            wr(en[i], 8'h00);
        end
        for (int i = 0; i < 5; i++)
        begin
            wr(a[i], 8'hFF);
            rd(a[i], e[i], "write all ones");
            wr(a[i], 8'h00);
        end
    endtask
    // event and software clear in one cycle: the event must win
    task automatic t_race();
        periph_event_type p;
        p = '0;
        p.comparator = 2'h1;
        wr(ANALOG_FLAGS_OFFSET, 8'h02);
        @(posedge mclk);
        req <= '{write: 1'h1, read: 1'h0, addr: ANALOG_FLAGS_OFFSET, wdata: 8'h00};
        pulse <= p;
        @(posedge mclk);
        req <= '0;
        pulse <= '0;
        rd(ANALOG_FLAGS_OFFSET, 8'h01, "set beats clear");
        wr(ANALOG_FLAGS_OFFSET, 8'h00);
    endtask
    task automatic t_serial();
        buf_op(4'h8);
        buf_op(4'h8);
        rd(SERIAL_FLAGS_OFFSET, 8'h30, "rx two bytes");
        buf_op(4'h4);
        rd(SERIAL_FLAGS_OFFSET, 8'h30, "rx one left");
        buf_op(4'h4);
        rd(SERIAL_FLAGS_OFFSET, 8'h10, "rx drained");
        buf_op(4'h2);
        rd(SERIAL_FLAGS_OFFSET, 8'h10, "tx one free");
        buf_op(4'h2);
        rd(SERIAL_FLAGS_OFFSET, 8'h00, "tx full");
        buf_op(4'h1);
        rd(SERIAL_FLAGS_OFFSET, 8'h10, "tx space while sending");
        buf_op(4'h1);
    endtask
    task automatic t_period();
        periph_event_type p;
        for (int i = 0; i < 3; i++)
        begin
            p = '0;
            p.period_match[i] = 1'h1;
            fire(p);
            rd(TIMER_FLAGS_OFFSET, 8'h02 << (2 * i), "period one to one");
            wr(TIMER_FLAGS_OFFSET, 8'h00);
            @(posedge mclk);
            postscale[i] <= 4'h2;
            fire(p);
            fire(p);
            rd(TIMER_FLAGS_OFFSET, 8'h00, "period early");
            fire(p);
            rd(TIMER_FLAGS_OFFSET, 8'h02 << (2 * i), "period one to three");
            wr(TIMER_FLAGS_OFFSET, 8'h00);
            @(posedge mclk);
            postscale[i] <= 4'h0;
        end
    endtask
    task automatic t_gate();
        @(posedge mclk);
        gate <= 3'h5;
        repeat (3) @(posedge mclk);
        rd(LCG_FLAGS_OFFSET, 8'h00, "gate opened");
        @(posedge mclk);
        gate <= 3'h0;
        repeat (3) @(posedge mclk);
        rd(LCG_FLAGS_OFFSET, 8'h05, "gate closed");
        wr(LCG_FLAGS_OFFSET, 8'h00);
    endtask
    task automatic t_irq();
        periph_event_type p;
        p = '0;
        p.overflow = 3'h1;
        wr(TIMER_FLAGS_OFFSET, 8'h00);
        wr(TIMER_ENABLE_OFFSET, 8'h01);
        wr(IRQ_CONTROL_OFFSET, 8'h40);
        #1;
        chk("irq idle", 8'h00, {7'h00, peripheral_irq});
        fire(p);
        #1;
        chk("irq raised", 8'h01, {7'h00, peripheral_irq});
        chk("cpu irq no global", 8'h00, {7'h00, cpu_irq});
        wr(IRQ_CONTROL_OFFSET, 8'hC0);
        #1;
        chk("cpu irq", 8'h01, {7'h00, cpu_irq});
        wr(TIMER_ENABLE_OFFSET, 8'h00);
        #1;
        chk("irq masked", 8'h00, {7'h00, peripheral_irq});
        rd(TIMER_FLAGS_OFFSET, 8'h01, "flag kept when masked");
        wr(TIMER_ENABLE_OFFSET, 8'h01);
        wr(TIMER_FLAGS_OFFSET, 8'h00);
        #1;
        chk("irq cleared", 8'h00, {7'h00, peripheral_irq});
        wr(IRQ_CONTROL_OFFSET, 8'h00);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'h0;
        req = '0;
        pulse = '0;
        gate = 3'h0;
        ops = 4'h0;
        postscale = '0;
        for (int c = 0; c < 4; c++)
            ccp_mode[c] = CCP_CAPTURE;
        bad_count = 0;
        check_count = 0;
        cycles = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        t_reset();
        t_pulses();
        t_race();
        t_ccp();
        t_reserved();
        t_serial();
        t_period();
        t_gate();
        t_irq();
        final_report();
    end
endmodule // tb
`default_nettype wire
